// ---- hdl/cti_pkg.sv ----
package cti_pkg;

  // ****************************************
  // Flag positions in the condition code byte
  // ****************************************
  localparam int CTI_FLG_C = 0; // Carry
  localparam int CTI_FLG_V = 1; // Overflow
  localparam int CTI_FLG_Z = 2; // Zero
  localparam int CTI_FLG_N = 3; // Negative
  localparam logic [7:0] CTI_CODE_RST = 8'h00; // Condition byte after reset
  localparam logic [4:0] CTI_CODE_USED = 5'h1F; // Implemented flag bits

  // ****************************************
  // Trap frame constants
  // ****************************************
  localparam logic [31:0] CTI_STK_WORD = 32'h0000_0002; // Word push step
  localparam logic [31:0] CTI_STK_LONG = 32'h0000_0004; // Long push step
  localparam logic [3:0] CTI_FRAME_FMT = 4'h0; // Short frame format code
  localparam logic [1:0] CTI_VEC_PAD = 2'h0; // Vector to byte offset padding

  // ****************************************
  // Interpolation operand fields
  // ****************************************
  localparam int CTI_FRAC_LSB = 0; // Fraction field low bit
  localparam int CTI_FRAC_MSB = 7; // Fraction field high bit
  localparam int CTI_OFS_LSB = 8; // Entry offset low bit
  localparam int CTI_OFS_MSB = 15; // Entry offset high bit
  localparam int CTI_FRAC_BITS = 8; // Divide by 256
  localparam logic [7:0] CTI_HALF = 8'h80; // One half in fraction units

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [3:0] {
    CTI_C_TRUE = 4'h0, CTI_C_FALSE = 4'h1,
    CTI_C_UNSIGNED_ABOVE = 4'h2, CTI_C_UNSIGNED_AT_MOST = 4'h3,
    CTI_C_CARRY_CLEAR = 4'h4, CTI_C_CARRY_SET = 4'h5,
    CTI_C_ZERO_CLEAR = 4'h6, CTI_C_ZERO_MATCH = 4'h7,
    CTI_C_OVF_CLEAR = 4'h8, CTI_C_OVF_SET = 4'h9,
    CTI_C_NONNEG = 4'hA, CTI_C_NEGATIVE = 4'hB,
    CTI_C_SIGNED_NOT_BELOW = 4'hC, CTI_C_SIGNED_BELOW = 4'hD,
    CTI_C_SIGNED_ABOVE = 4'hE, CTI_C_SIGNED_AT_MOST = 4'hF
  } cti_cond_e;

  typedef enum logic [3:0] {
    CTI_OP_TRAP = 4'h0, CTI_OP_COND_TRAP = 4'h1, CTI_OP_OVF_TRAP = 4'h2,
    CTI_OP_IMM_AND = 4'h3, CTI_OP_IMM_XOR = 4'h4, CTI_OP_IMM_OR = 4'h5,
    CTI_OP_MOVE_TO = 4'h6, CTI_OP_MOVE_FROM = 4'h7, CTI_OP_BRANCH = 4'h8,
    CTI_OP_TEST = 4'h9, CTI_OP_INTERP = 4'hA
  } cti_op_e;

  typedef enum logic [1:0] {
    CTI_SZ_BYTE = 2'h0, CTI_SZ_WORD = 2'h1, CTI_SZ_LONG = 2'h2, CTI_SZ_BAD = 2'h3
  } cti_size_e;

  typedef enum logic [1:0] {
    CTI_IMM_NONE = 2'h0, CTI_IMM_16 = 2'h1, CTI_IMM_32 = 2'h2, CTI_IMM_BAD = 2'h3
  } cti_imm_e;

  typedef enum logic [3:0] {
    CTI_ST_IDLE = 4'b0001, CTI_ST_FMT = 4'b0010,
    CTI_ST_PC = 4'b0100, CTI_ST_STATUS = 4'b1000
  } cti_st_e;

  // Whole state of the top module
  typedef struct packed {
    cti_st_e st;
    logic [7:0] cbyte;
    logic [31:0] sptr;
    logic [7:0] vec;
    logic busy;
    logic done;
    logic cond_true;
    logic trap;
    logic wr;
    logic wlong;
    logic [31:0] waddr;
    logic [31:0] wdata;
    logic pc_load;
    logic [31:0] vec_addr;
    logic [31:0] result;
    logic [7:0] frac;
    logic [15:0] move_data;
    logic move_vld;
    logic [7:0] entry_sel;
    logic illegal;
  } cti_state_s;

endpackage

// ---- hdl/cti_cond_eval.sv ----
`timescale 1ns/100ps
module cti_cond_eval
  import cti_pkg::*;
(
  input wire logic [3:0] i_cond,
  input wire logic [7:0] i_cond_byte,
  output logic o_true
);

  // ****************************************
  // Flag taps
  // ****************************************
  logic c;
  logic v;
  logic z;
  logic n;
  assign c = i_cond_byte[CTI_FLG_C];
  assign v = i_cond_byte[CTI_FLG_V];
  assign z = i_cond_byte[CTI_FLG_Z];
  assign n = i_cond_byte[CTI_FLG_N];

  // Logical expression per encoding, 1 is true
  // boolean test result
  always_comb begin
    case (cti_cond_e'(i_cond))
      CTI_C_TRUE: o_true = 1'b1;
      CTI_C_FALSE: o_true = 1'b0;
      CTI_C_UNSIGNED_ABOVE: o_true = !c && !z;
      CTI_C_UNSIGNED_AT_MOST: o_true = c || z;
      CTI_C_CARRY_CLEAR: o_true = !c;
      CTI_C_CARRY_SET: o_true = c;
      CTI_C_ZERO_CLEAR: o_true = !z;
      CTI_C_ZERO_MATCH: o_true = z;
      CTI_C_OVF_CLEAR: o_true = !v;
      CTI_C_OVF_SET: o_true = v;
      CTI_C_NONNEG: o_true = !n;
      CTI_C_NEGATIVE: o_true = n;
      CTI_C_SIGNED_NOT_BELOW: o_true = (n == v);
      CTI_C_SIGNED_BELOW: o_true = (n != v);
      CTI_C_SIGNED_ABOVE: o_true = !z && (n == v);
      default: o_true = z || (n != v);
    endcase
  end

endmodule

// ---- hdl/cti_interp.sv ----
`timescale 1ns/100ps
module cti_interp
  import cti_pkg::*;
(
  input wire logic [31:0] i_entry_lo,
  input wire logic [31:0] i_entry_hi,
  input wire logic [7:0] i_frac,
  input wire logic [1:0] i_size,
  input wire logic i_signed,
  input wire logic i_round,
  output logic [31:0] o_int,
  output logic [7:0] o_frac
);

  // Operand extended to 33 bits by size and sign mode
  function automatic logic signed [32:0] ext(input logic [31:0] x, input logic [1:0] sz,
                                             input logic sg);
    logic signed [32:0] r;
    r = 33'sh0;
    case (cti_size_e'(sz))
      CTI_SZ_BYTE: r = {{25{sg & x[7]}}, x[7:0]};
      CTI_SZ_WORD: r = {{17{sg & x[15]}}, x[15:0]};
      default: r = {sg & x[31], x};
    endcase
    return r;
  endfunction

  // ****************************************
  // Datapath
  // ****************************************
  logic signed [32:0] a; // Selected entry
  logic signed [32:0] b; // Next entry
  logic signed [33:0] diff; // Step to next entry
  logic signed [43:0] num; // Result scaled by 256
  logic signed [35:0] q; // Integer part, floor
  logic [7:0] rem; // Fractional part
  logic up; // Rounding increment
  logic [31:0] res; // Integer result before size mask

  always_comb begin
    a = ext(i_entry_lo, i_size, i_signed);
    b = ext(i_entry_hi, i_size, i_signed);
    diff = 34'(b) - 34'(a);
    num = (44'(a) <<< CTI_FRAC_BITS) + 44'(diff) * $signed({36'h0, i_frac});
    q = 36'(num >>> CTI_FRAC_BITS);
    rem = num[7:0];
    up = i_round && ((rem > CTI_HALF) || ((rem == CTI_HALF) && q[0]));
    res = q[31:0] + {31'h0, up};
    case (cti_size_e'(i_size))
      CTI_SZ_BYTE: o_int = {24'h0, res[7:0]};
      CTI_SZ_WORD: o_int = {16'h0, res[15:0]};
      default: o_int = res;
    endcase
    // Unrounded variants keep the fraction
    o_frac = i_round ? 8'h00 : rem;
  end

endmodule

// ---- hdl/cti_core.sv ----
`timescale 1ns/100ps
// How it works
// - Trap pushes format, pc, status; vector loads
// - Conditional trap: optional operand, trap if true
// - Overflow trap only when overflow set
// - Immediate and/xor/or onto condition byte
// - Word moves into and out of condition byte
// - Condition test yields one true, zero false
// - Encoding 0000 true, 0001 false
// - Always-false refused for branch only
// - 0110 zero clear, 0111 zero set
// - 1000 overflow clear, 1001 overflow set
// - 1100 N equals V, 1101 differ
// - 1110 greater, 1111 less or equal
// - Four interpolation variants, three result sizes
// - Table or register pair entries
// - Offset bits 15:8, fraction bits 7:0
// - Entry plus fraction times step over 256
// - Rounded variants round half to even
module cti_core
  import cti_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_op_valid,
  input wire logic [3:0] i_op_code,
  input wire logic [3:0] i_cond,
  input wire logic [1:0] i_imm_size,
  input wire logic [31:0] i_imm,
  input wire logic [7:0] i_vector,
  input wire logic [31:0] i_vbr,
  input wire logic [31:0] i_pc,
  input wire logic [31:0] i_stack_ptr,
  input wire logic [7:0] i_sys_byte,
  input wire logic [15:0] i_move_src,
  input wire logic i_flag_load,
  input wire logic [4:0] i_flag_val,
  input wire logic i_tbl_signed,
  input wire logic i_tbl_round,
  input wire logic [1:0] i_tbl_size,
  input wire logic i_tbl_reg_pair,
  input wire logic [31:0] i_index,
  input wire logic [31:0] i_entry_lo,
  input wire logic [31:0] i_entry_hi,
  output logic o_busy,
  output logic o_done,
  output logic o_cond_true,
  output logic o_trap_taken,
  output logic o_stack_wr,
  output logic o_stack_long,
  output logic [31:0] o_stack_addr,
  output logic [31:0] o_stack_data,
  output logic [31:0] o_stack_ptr,
  output logic o_pc_load,
  output logic [31:0] o_vec_addr,
  output logic [7:0] o_cond_code,
  output logic [15:0] o_move_data,
  output logic o_move_valid,
  output logic [31:0] o_result,
  output logic [7:0] o_result_frac,
  output logic [7:0] o_entry_sel,
  output logic o_illegal
);

  // ****************************************
  // State
  // ****************************************
  cti_state_s s_q; // Registered state
  cti_state_s s_d; // Next state
  cti_op_e op; // Decoded operation
  logic take; // Operation accepted this cycle
  logic cond_now; // Condition result on current flags
  logic [31:0] tbl_int; // Interpolated integer part
  logic [7:0] tbl_frac; // Interpolated fraction
  logic [15:0] fmt_word; // Format and vector offset word
  logic trap_go; // Unconditional trap accepted
  logic ctrap_go; // Conditional trap accepted
  logic vtrap_go; // Overflow trap accepted
  logic test_go; // Branch or test accepted

  assign op = cti_op_e'(i_op_code);
  assign take = i_op_valid && (s_q.st == CTI_ST_IDLE);
  assign fmt_word = {CTI_FRAME_FMT, CTI_VEC_PAD, i_vector, CTI_VEC_PAD};
  assign trap_go = take && (op == CTI_OP_TRAP);
  assign ctrap_go = take && (op == CTI_OP_COND_TRAP);
  assign vtrap_go = take && (op == CTI_OP_OVF_TRAP);
  assign test_go = take && ((op == CTI_OP_BRANCH) || (op == CTI_OP_TEST));

  // ****************************************
  // Condition evaluator
  // ****************************************
  cti_cond_eval u_cond (
    .i_cond(i_cond),
    .i_cond_byte(s_q.cbyte),
    .o_true(cond_now)
  );

  // ****************************************
  // Interpolation datapath
  // ****************************************
  cti_interp u_interp (
    .i_entry_lo(i_entry_lo),
    .i_entry_hi(i_entry_hi),
    .i_frac(i_index[CTI_FRAC_MSB:CTI_FRAC_LSB]),
    .i_size(i_tbl_size),
    .i_signed(i_tbl_signed),
    .i_round(i_tbl_round),
    .o_int(tbl_int),
    .o_frac(tbl_frac)
  );

  // ****************************************
  // Next state
  // ****************************************
  // One-cycle strobes fall back, levels hold
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.trap = 1'b0;
    s_d.wr = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.move_vld = 1'b0;
    s_d.illegal = 1'b0;
    // Flags from the ALU when no byte op runs
    if (i_flag_load && !(take && (op inside {CTI_OP_IMM_AND, CTI_OP_IMM_XOR,
                                            CTI_OP_IMM_OR, CTI_OP_MOVE_TO}))) begin
      s_d.cbyte = {3'h0, i_flag_val & CTI_CODE_USED};
    end
    case (s_q.st)
      CTI_ST_IDLE: begin
        if (take) begin
          case (op)
            CTI_OP_TRAP: begin
              s_d.vec = i_vector;
              s_d.trap = 1'b1;
            end
            CTI_OP_COND_TRAP: begin
              s_d.vec = i_vector;
              s_d.cond_true = cond_now;
              if (cti_imm_e'(i_imm_size) == CTI_IMM_BAD) begin
                s_d.illegal = 1'b1;
                s_d.done = 1'b1;
              end else if (cond_now) begin
                s_d.trap = 1'b1;
              end else begin
                s_d.done = 1'b1;
              end
            end
            CTI_OP_OVF_TRAP: begin
              s_d.vec = i_vector;
              s_d.cond_true = s_q.cbyte[CTI_FLG_V];
              if (s_q.cbyte[CTI_FLG_V]) begin
                s_d.trap = 1'b1;
              end else begin
                s_d.done = 1'b1;
              end
            end
            CTI_OP_IMM_AND: begin
              s_d.cbyte = s_q.cbyte & i_imm[7:0];
              s_d.done = 1'b1;
            end
            CTI_OP_IMM_XOR: begin
              s_d.cbyte = s_q.cbyte ^ i_imm[7:0];
              s_d.done = 1'b1;
            end
            CTI_OP_IMM_OR: begin
              s_d.cbyte = s_q.cbyte | i_imm[7:0];
              s_d.done = 1'b1;
            end
            CTI_OP_MOVE_TO: begin
              s_d.cbyte = i_move_src[7:0];
              s_d.done = 1'b1;
            end
            CTI_OP_MOVE_FROM: begin
              s_d.move_data = {8'h00, s_q.cbyte};
              s_d.move_vld = 1'b1;
              s_d.done = 1'b1;
            end
            CTI_OP_BRANCH: begin
              s_d.cond_true = cond_now;
              s_d.illegal = (cti_cond_e'(i_cond) == CTI_C_FALSE);
              s_d.done = 1'b1;
            end
            CTI_OP_TEST: begin
              s_d.cond_true = cond_now;
              s_d.done = 1'b1;
            end
            CTI_OP_INTERP: begin
              if (cti_size_e'(i_tbl_size) == CTI_SZ_BAD) begin
                s_d.illegal = 1'b1;
              end else begin
                s_d.result = tbl_int;
                s_d.frac = tbl_frac;
              end
              s_d.entry_sel = i_tbl_reg_pair ? 8'h00 : i_index[CTI_OFS_MSB:CTI_OFS_LSB];
              s_d.done = 1'b1;
            end
            default: begin
              s_d.illegal = 1'b1;
              s_d.done = 1'b1;
            end
          endcase
          if (s_d.trap) begin
            s_d.st = CTI_ST_FMT;
            s_d.sptr = i_stack_ptr - CTI_STK_WORD;
            s_d.waddr = i_stack_ptr - CTI_STK_WORD;
            s_d.wdata = {16'h0000, fmt_word};
            s_d.wlong = 1'b0;
            s_d.wr = 1'b1;
          end
        end
      end
      CTI_ST_FMT: begin
        s_d.st = CTI_ST_PC;
        s_d.sptr = s_q.sptr - CTI_STK_LONG;
        s_d.waddr = s_q.sptr - CTI_STK_LONG;
        s_d.wdata = i_pc;
        s_d.wlong = 1'b1;
        s_d.wr = 1'b1;
      end
      CTI_ST_PC: begin
        s_d.st = CTI_ST_STATUS;
        s_d.sptr = s_q.sptr - CTI_STK_WORD;
        s_d.waddr = s_q.sptr - CTI_STK_WORD;
        s_d.wdata = {16'h0000, i_sys_byte, s_q.cbyte};
        s_d.wlong = 1'b0;
        s_d.wr = 1'b1;
      end
      CTI_ST_STATUS: begin
        s_d.st = CTI_ST_IDLE;
        s_d.vec_addr = i_vbr + {22'h0, s_q.vec, CTI_VEC_PAD};
        s_d.pc_load = 1'b1;
        s_d.done = 1'b1;
      end
      default: s_d.st = CTI_ST_IDLE;
    endcase
    s_d.busy = (s_d.st != CTI_ST_IDLE);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{st: CTI_ST_IDLE, cbyte: CTI_CODE_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs, all from the state register
  // ****************************************
  assign o_busy = s_q.busy;
  assign o_done = s_q.done;
  assign o_cond_true = s_q.cond_true;
  assign o_trap_taken = s_q.trap;
  assign o_stack_wr = s_q.wr;
  assign o_stack_long = s_q.wlong;
  assign o_stack_addr = s_q.waddr;
  assign o_stack_data = s_q.wdata;
  assign o_stack_ptr = s_q.sptr;
  assign o_pc_load = s_q.pc_load;
  assign o_vec_addr = s_q.vec_addr;
  assign o_cond_code = s_q.cbyte;
  assign o_move_data = s_q.move_data;
  assign o_move_valid = s_q.move_vld;
  assign o_result = s_q.result;
  assign o_result_frac = s_q.frac;
  assign o_entry_sel = s_q.entry_sel;
  assign o_illegal = s_q.illegal;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Three pushes then the vector load
  property p_trap_frame;
    trap_go |=> o_stack_wr ##1 o_stack_wr ##1 o_stack_wr ##1 (o_pc_load && !o_busy);
  endproperty
  a_trap_frame: assert property (p_trap_frame) else $error("trap frame order wrong");

  // Program counter lands six bytes down
  property p_trap_pc;
    trap_go |-> ##2 (o_stack_addr == $past(i_stack_ptr, 2) - 32'h6) && o_stack_long;
  endproperty
  a_trap_pc: assert property (p_trap_pc) else $error("pc push address wrong");

  // True conditional trap starts a frame
  property p_ctrap_true;
    ctrap_go && cond_now && (i_imm_size != 2'h3) |=> o_trap_taken && o_stack_wr;
  endproperty
  a_ctrap_true: assert property (p_ctrap_true) else $error("true trap not taken");

  // False trap test leaves flow alone
  property p_no_frame;
    (ctrap_go && !cond_now) || (vtrap_go && !s_q.cbyte[CTI_FLG_V])
      |=> !o_stack_wr && !o_trap_taken && o_done ##1 !o_pc_load;
  endproperty
  a_no_frame: assert property (p_no_frame) else $error("frame on false test");

  // Overflow trap follows the overflow flag
  property p_ovf_trap;
    vtrap_go |=> o_trap_taken == $past(s_q.cbyte[CTI_FLG_V]);
  endproperty
  a_ovf_trap: assert property (p_ovf_trap) else $error("overflow trap mismatch");

  // Immediate and combines with the old byte
  property p_imm_and;
    take && (op == CTI_OP_IMM_AND) |=> o_cond_code == ($past(o_cond_code) & $past(i_imm[7:0]));
  endproperty
  a_imm_and: assert property (p_imm_and) else $error("immediate and wrong");

  // Move out carries the byte zero extended
  property p_move_from;
    take && (op == CTI_OP_MOVE_FROM)
      |=> o_move_valid && (o_move_data == {8'h00, $past(o_cond_code)});
  endproperty
  a_move_from: assert property (p_move_from) else $error("move out wrong");

  // Fixed encodings
  property p_fixed_cond;
    test_go && (i_cond[3:1] == 3'h0) |=> o_cond_true == !$past(i_cond[0]);
  endproperty
  a_fixed_cond: assert property (p_fixed_cond) else $error("fixed condition wrong");

  // Signed not below compares N and V
  property p_not_below;
    test_go && (i_cond == 4'hC)
      |=> o_cond_true == ($past(o_cond_code[CTI_FLG_N]) == $past(o_cond_code[CTI_FLG_V]));
  endproperty
  a_not_below: assert property (p_not_below) else $error("signed compare wrong");

  // Branch refuses always-false
  property p_branch_false;
    take && (op == CTI_OP_BRANCH) |=> o_illegal == ($past(i_cond) == 4'h1);
  endproperty
  a_branch_false: assert property (p_branch_false) else $error("false branch kept");

  // Table offset comes from bits 15 to 8
  property p_entry_sel;
    take && (op == CTI_OP_INTERP) && !i_tbl_reg_pair |=> o_entry_sel == $past(i_index[15:8]);
  endproperty
  a_entry_sel: assert property (p_entry_sel) else $error("entry offset wrong");

  c_trap: cover property (trap_go ##4 o_pc_load);
  c_ctrap_false: cover property (ctrap_go && !cond_now);
  c_interp: cover property (take && (op == CTI_OP_INTERP) && i_tbl_round);
  c_branch_false: cover property (take && (op == CTI_OP_BRANCH) && (i_cond == 4'h1));

endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import cti_pkg::*;
  // ****************
  // Signals
  // ****************
  logic clk, rst_n, vld, fl_ld, t_sg, t_rd, t_pr; // Clock, reset, strobes
  logic [3:0] opc, cnd; // Operation and condition
  logic [31:0] imm, vbr, pc, stk, idx, elo, ehi; // Wide operands
  logic [15:0] msrc; // Move source
  logic [7:0] vec, sysb; // Vector, status byte
  logic [4:0] fv; // Flag values
  logic [1:0] isz, tsz; // Operand sizes
  logic busy, done, ctrue, ttk, swr, slong, pld, mvv, ill; // Single-bit outputs
  logic [31:0] sadr, sdat, ostk, vadr, res; // Wide outputs
  logic [7:0] cbyte, rfr, esel; // Byte outputs
  logic [15:0] mvd; // Move result
  int n_fail, checks; // Counters

  cti_core u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_op_valid(vld), .i_op_code(opc),
    .i_cond(cnd), .i_imm_size(isz), .i_imm(imm), .i_vector(vec), .i_vbr(vbr), .i_pc(pc),
    .i_stack_ptr(stk), .i_sys_byte(sysb), .i_move_src(msrc), .i_flag_load(fl_ld),
    .i_flag_val(fv), .i_tbl_signed(t_sg), .i_tbl_round(t_rd), .i_tbl_size(tsz),
    .i_tbl_reg_pair(t_pr), .i_index(idx), .i_entry_lo(elo), .i_entry_hi(ehi), .o_busy(busy),
    .o_done(done), .o_cond_true(ctrue), .o_trap_taken(ttk), .o_stack_wr(swr),
    .o_stack_long(slong), .o_stack_addr(sadr), .o_stack_data(sdat), .o_stack_ptr(ostk),
    .o_pc_load(pld), .o_vec_addr(vadr), .o_cond_code(cbyte), .o_move_data(mvd),
    .o_move_valid(mvv), .o_result(res), .o_result_frac(rfr), .o_entry_sel(esel),
    .o_illegal(ill));

  // ****************
  // Helpers
  // ****************
  // Clock at 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One idle edge, then one request held across its taking edge
  task go(input logic [3:0] op);
    @(posedge clk);
    #10;
    opc = op;
    vld = 1'b1;
    @(posedge clk);
    #10;
    vld = 1'b0;
  endtask

  // Load flags as the ALU would
  task flags(input logic [4:0] v);
    fv = v;
    fl_ld = 1'b1;
    @(posedge clk);
    #10;
    fl_ld = 1'b0;
  endtask

  // Reference condition, flags as N Z V C
  function automatic logic mdl(input logic [3:0] c, input logic [3:0] f);
    logic n, z, v, k;
    n = f[3];
    z = f[2];
    v = f[1];
    k = f[0];
    case (c)
      4'h0: mdl = 1'b1;
      4'h1: mdl = 1'b0;
      4'h2: mdl = !k && !z;
      4'h3: mdl = k || z;
      4'h4: mdl = !k;
      4'h5: mdl = k;
      4'h6: mdl = !z;
      4'h7: mdl = z;
      4'h8: mdl = !v;
      4'h9: mdl = v;
      4'hA: mdl = !n;
      4'hB: mdl = n;
      4'hC: mdl = n == v;
      4'hD: mdl = n != v;
      4'hE: mdl = !z && (n == v);
      default: mdl = z || (n != v);
    endcase
  endfunction

  // Frame walk after a taken trap, outputs of cycle 1 on entry
  task walk(input logic [7:0] cb);
    chk("taken", ttk, 1);
    chk("a1", sadr, stk - 32'h2);
    chk("d1", sdat[15:0], {CTI_FRAME_FMT, 2'h0, vec, CTI_VEC_PAD});
    chk("busy", busy, 1);
    @(posedge clk);
    #10;
    chk("a2", sadr, stk - 32'h6);
    chk("d2", sdat, pc);
    chk("long", slong, 1);
    @(posedge clk);
    #10;
    chk("a3", sadr, stk - 32'h8);
    chk("d3", sdat[15:0], {sysb, cb});
    @(posedge clk);
    #10;
    chk("pcld", {pld, done, busy}, 3'h6);
    chk("vadr", vadr, vbr + {22'h0, vec, 2'h0});
    chk("stk", ostk, stk - 32'h8);
  endtask

  // ****************
  // Scenarios
  // ****************
  // Every encoding against every flag pattern
  task t_cond;
    for (int f = 0; f < 16; f++) begin
      flags({1'b0, f[3:0]});
      for (int c = 0; c < 16; c++) begin
        cnd = c[3:0];
        go(CTI_OP_TEST);
        chk("cond", {done, ctrue}, {1'b1, mdl(c[3:0], f[3:0])});
      end
    end
    cnd = 4'h1;
    go(CTI_OP_BRANCH);
    chk("br_f", {ill, ctrue}, 2'h2);
    cnd = 4'h0;
    go(CTI_OP_BRANCH);
    chk("br_t", {ill, ctrue}, 2'h1);
  endtask

  // Immediate ops and moves on the condition byte
  task t_ccr;
    flags(5'h0F);
    imm = 32'h0000_0005;
    go(CTI_OP_IMM_AND);
    chk("and", cbyte, 8'h05);
    imm = 32'h0000_001A;
    go(CTI_OP_IMM_XOR);
    chk("xor", cbyte, 8'h1F);
    flags(5'h00);
    imm = 32'h0000_0010;
    go(CTI_OP_IMM_OR);
    chk("or", cbyte, 8'h10);
    msrc = 16'hAB12;
    go(CTI_OP_MOVE_TO);
    chk("mvto", cbyte, 8'h12);
    go(CTI_OP_MOVE_FROM);
    chk("mvfr", {mvv, mvd}, {1'b1, 16'h0012});
  endtask

  // Traps taken and not taken
  task t_trap;
    vec = 8'h21;
    vbr = 32'h0000_0400;
    pc = 32'hABCD_0124;
    stk = 32'h0000_2000;
    sysb = 8'h27;
    flags(5'h00);
    go(CTI_OP_TRAP);
    walk(8'h00);
    cnd = 4'h7;
    isz = 2'h1;
    go(CTI_OP_COND_TRAP);
    chk("nt", {done, ttk, swr, ctrue}, 4'h8);
    @(posedge clk);
    #10;
    chk("nt2", {swr, pld}, 2'h0);
    go(CTI_OP_OVF_TRAP);
    chk("nv", {ttk, swr}, 2'h0);
    flags(5'h06);
    isz = 2'h2;
    go(CTI_OP_COND_TRAP);
    walk(8'h06);
    go(CTI_OP_OVF_TRAP);
    walk(8'h06);
    isz = 2'h3;
    go(CTI_OP_COND_TRAP);
    chk("isz", {ill, ttk}, 2'h2);
  endtask

  // One interpolation against its worked result
  task interp(input logic sg, rd, pr, input logic [1:0] sz, input logic [31:0] lo, hi,
              input logic [15:0] ix, input logic [31:0] r, input logic [7:0] fr, sl);
    t_sg = sg;
    t_rd = rd;
    t_pr = pr;
    tsz = sz;
    elo = lo;
    ehi = hi;
    idx = {16'h0, ix};
    go(CTI_OP_INTERP);
    chk("res", res, r);
    chk("frac", rfr, fr);
    chk("sel", {done, esel}, {1'b1, sl});
  endtask

  task results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    {rst_n, vld, fl_ld, t_sg, t_rd, t_pr, opc, cnd, imm, vbr, pc, stk} = '0;
    {idx, elo, ehi, msrc, vec, sysb, fv, isz, tsz} = '0;
    n_fail = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    #10;
    rst_n = 1'b1;
    chk("rst", cbyte, CTI_CODE_RST);
    t_cond();
    t_ccr();
    t_trap();
    // variants, sizes and both entry forms
    interp(0, 0, 0, CTI_SZ_WORD, 1669, 1679, 16'hA380, 1674, 8'h00, 8'hA3);
    interp(0, 0, 1, CTI_SZ_LONG, 0, 1, 16'h0080, 0, 8'h80, 8'h00);
    interp(0, 1, 1, CTI_SZ_WORD, 0, 1, 16'h0080, 0, 8'h00, 8'h00);
    interp(0, 1, 1, CTI_SZ_WORD, 1, 2, 16'h0080, 2, 8'h00, 8'h00);
    interp(1, 1, 1, CTI_SZ_WORD, -2, -1, 16'h0080, 32'hFFFE, 8'h00, 8'h00);
    interp(1, 0, 0, CTI_SZ_BYTE, 8'h10, 8'h20, 16'h0240, 8'h14, 8'h00, 8'h02);
    // Unsupported result size is refused
    tsz = CTI_SZ_BAD;
    go(CTI_OP_INTERP);
    chk("tsz", {ill, done}, 2'h3);
    results();
  end

  // Watchdog against a hang
  initial begin
    #(3000 * 100);
    n_fail++;
    results();
  end
endmodule
